// ==== inc/lrsc_cfg.svh ====
`ifndef LRSC_CFG_SVH
`define LRSC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LRSC_OFS_CMD       8'h00
`define LRSC_OFS_OPERAND   8'h04
`define LRSC_OFS_COUNT     8'h08
`define LRSC_OFS_IMM       8'h0C
`define LRSC_OFS_FLAGS     8'h10
`define LRSC_OFS_STATUS    8'h14
`define LRSC_OFS_EA        8'h18
`define LRSC_OFS_MEMDATA   8'h1C
// ----------------------------------------
// field positions
// ----------------------------------------
`define LRSC_CMD_OP_LSB    0
`define LRSC_CMD_REG_LSB   8
`define LRSC_CMD_MEM_BIT   11
`define LRSC_STS_BUSY_BIT  0
`define LRSC_STS_ERR_BIT   1
`define LRSC_FLAG_CF       0
`define LRSC_FLAG_PF       2
`define LRSC_FLAG_ZF       6
`define LRSC_FLAG_SF       7
`define LRSC_FLAG_OF       11
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define LRSC_FLAGS_RST     16'h0000
`define LRSC_FLAGS_MASK    16'h0FD5
`define LRSC_CNT_MASK      8'h1F
// ----------------------------------------
// opcodes
// ----------------------------------------
`define LRSC_OP_ONE_B      8'hD0
`define LRSC_OP_ONE_W      8'hD1
`define LRSC_OP_CL_B       8'hD2
`define LRSC_OP_CL_W       8'hD3
`define LRSC_OP_IMM_B      8'hC0
`define LRSC_OP_IMM_W      8'hC1
`define LRSC_OP_STC        8'hF9
`define LRSC_SHR_REGF      3'h5
// ----------------------------------------
// cycle counts
// ----------------------------------------
`define LRSC_LAT_ONE_REG   6'h02
`define LRSC_LAT_ONE_MEM   6'h0F
`define LRSC_LAT_MUL_REG   6'h05
`define LRSC_LAT_MUL_MEM   6'h11
`define LRSC_LAT_STC       6'h02
// ----------------------------------------
// bus responses
// ----------------------------------------
`define LRSC_RESP_OKAY     2'h0
`define LRSC_RESP_SLVERR   2'h2
`endif

// ==== inc/lrsc_pkg.sv ====
package lrsc_pkg;
  typedef enum logic {LRSC_IDLE, LRSC_RUN} lrsc_state_t;
  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] regf;
    logic       mem;
  } lrsc_cmd_t;
endpackage

// ==== rtl/lrsc_mem.sv ====
`timescale 1ns/10ps
module lrsc_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  // clock and control
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // single port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  // write-through so a read right after writeback sees the new word
  always_comb begin
    rdata_d = we_i ? wdata_i : mem_q[addr_i];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = rdata_q;
endmodule

// ==== rtl/lrsc_top.sv ====
`timescale 1ns/10ps
`include "lrsc_cfg.svh"
// ----------------------------------------
// Overview of operation
// - Single-shift opcodes D0 and D1 with reg field 5 shift the operand right by one position.
// - Opcodes D2 and D3 with reg field 5 take the count from the low byte of the count register.
// - Opcodes C0 and C1 with reg field 5 take the count from the immediate byte after the operand.
// - A single shift lasts 2 cycles on a register operand and 15 on a memory operand.
// - A shift by n lasts 5 plus n cycles on a register and 17 plus n cycles on memory.
// - Each step fills the top bit with zero, an unsigned halving.
// - Each step moves the low bit into carry, so carry ends holding the last bit out.
// - The count is cut to its low five bits, so no shift exceeds 31 positions.
// - The count comes from the immediate or the count register as the opcode selects.
// - A zero count leaves every flag alone; other counts update carry, sign, zero and parity, and only a count of one also updates overflow.
// - Opcode F9 sets carry, takes no operand and lasts 2 cycles.
// - Setting carry forces flag bit 0 high and leaves every other flag unchanged.
// ----------------------------------------
module lrsc_top #(
  parameter int MEM_AW = 4
) (
  // clock, reset, enable
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        CE_I,
  // axi4-lite write
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // status
  output logic             BUSY_O,
  output logic             CARRY_O
);
  import lrsc_pkg::*;

  generate
    if (MEM_AW < 1 || MEM_AW > 8) begin : g_bad_aw
      $error("MEM_AW must lie between 1 and 8");
    end
  endgenerate

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ----------------------------------------
  // bus channels
  // ----------------------------------------
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]        awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d, rd_mux;
  logic              wr_go, rd_go, wr_hit, rd_hit;

  // ----------------------------------------
  // registers and execution
  // ----------------------------------------
  lrsc_state_t       st_q, st_d;
  lrsc_cmd_t         cmd_q, cmd_d, nc;
  logic [15:0]       operand_q, operand_d, flags_q, flags_d, opnd_q, opnd_d;
  logic [7:0]        count_low_q, count_low_d, imm_q, imm_d;
  logic [MEM_AW-1:0] ea_q, ea_d, ea_x_q, ea_x_d;
  logic              err_q, err_d, busy_q, busy_d, cout_q, cout_d, omsb_q, omsb_d;
  logic [5:0]        cyc_q, cyc_d, lat_new;
  logic [4:0]        steps_q, steps_d, n_q, n_d, n_new, cl_cnt, imm_cnt;
  logic              start, commit, step, single, by_cl, by_imm, is_stc, legal;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [15:0]       mem_wdata, mem_rdata;

  assign cl_cnt  = 5'(count_low_q & `LRSC_CNT_MASK);
  assign imm_cnt = 5'(imm_q & `LRSC_CNT_MASK);
  assign commit  = (st_q == LRSC_RUN) && (cyc_q == 6'h01);
  assign step    = (st_q == LRSC_RUN) && (steps_q != 5'h00);

  always_comb begin
    wr_hit = 1'b1;
    case (awaddr_q)
      `LRSC_OFS_CMD, `LRSC_OFS_OPERAND, `LRSC_OFS_COUNT, `LRSC_OFS_IMM,
      `LRSC_OFS_FLAGS, `LRSC_OFS_STATUS, `LRSC_OFS_EA, `LRSC_OFS_MEMDATA: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (S_AXI_ARADDR_I)
      `LRSC_OFS_CMD:     rd_mux = {20'h00000, cmd_q.mem, cmd_q.regf, cmd_q.opcode};
      `LRSC_OFS_OPERAND: rd_mux = {16'h0000, operand_q};
      `LRSC_OFS_COUNT:   rd_mux = {24'h000000, count_low_q};
      `LRSC_OFS_IMM:     rd_mux = {24'h000000, imm_q};
      `LRSC_OFS_FLAGS:   rd_mux = {16'h0000, flags_q};
      `LRSC_OFS_STATUS:  rd_mux = {30'h0, err_q, busy_q};
      `LRSC_OFS_EA:      rd_mux = 32'(ea_q);
      `LRSC_OFS_MEMDATA: rd_mux = {16'h0000, mem_rdata};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_go     = aw_have_q & w_have_q & ~bvalid_q;
    rd_go     = S_AXI_ARVALID_I & arready_q;
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    if (S_AXI_AWVALID_I & awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d  = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I & wready_q) begin
      w_have_d = 1'b1;
      wdata_d  = S_AXI_WDATA_I;
      wstrb_d  = S_AXI_WSTRB_I;
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
    end
    bvalid_d  = bvalid_q ? ~S_AXI_BREADY_I : wr_go;
    bresp_d   = wr_go ? (wr_hit ? `LRSC_RESP_OKAY : `LRSC_RESP_SLVERR) : bresp_q;
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
    rvalid_d  = rvalid_q ? ~S_AXI_RREADY_I : rd_go;
    arready_d = ~rvalid_d;
    rdata_d   = rd_go ? rd_mux : rdata_q;
    rresp_d   = rd_go ? (rd_hit ? `LRSC_RESP_OKAY : `LRSC_RESP_SLVERR) : rresp_q;
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end else if (CE_I) begin
      aw_have_q <= aw_have_d;
      awaddr_q  <= awaddr_d;
      w_have_q  <= w_have_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // decode of a command word being written
  always_comb begin
    nc.opcode = wdata_q[`LRSC_CMD_OP_LSB +: 8];
    nc.regf   = wdata_q[`LRSC_CMD_REG_LSB +: 3];
    nc.mem    = wdata_q[`LRSC_CMD_MEM_BIT];
    single    = nc.opcode inside {`LRSC_OP_ONE_B, `LRSC_OP_ONE_W};
    by_cl     = nc.opcode inside {`LRSC_OP_CL_B, `LRSC_OP_CL_W};
    by_imm    = nc.opcode inside {`LRSC_OP_IMM_B, `LRSC_OP_IMM_W};
    is_stc    = nc.opcode == `LRSC_OP_STC;
    legal     = is_stc || ((single || by_cl || by_imm) && nc.regf == `LRSC_SHR_REGF);
    if (is_stc) begin
      nc.mem = 1'b0;
    end
    // count source picked by opcode
    n_new = is_stc ? 5'h00 : single ? 5'h01 : by_cl ? cl_cnt : imm_cnt;
    if (is_stc) begin
      lat_new = `LRSC_LAT_STC;
    end else if (single) begin
      lat_new = nc.mem ? `LRSC_LAT_ONE_MEM : `LRSC_LAT_ONE_REG;
    end else begin
      lat_new = (nc.mem ? `LRSC_LAT_MUL_MEM : `LRSC_LAT_MUL_REG) + {1'b0, n_new};
    end
  end

  always_comb begin
    st_d        = st_q;
    cmd_d       = cmd_q;
    operand_d   = operand_q;
    flags_d     = flags_q;
    count_low_d = count_low_q;
    imm_d       = imm_q;
    ea_d        = ea_q;
    ea_x_d      = ea_x_q;
    err_d       = err_q;
    cyc_d       = cyc_q;
    steps_d     = steps_q;
    n_d         = n_q;
    opnd_d      = opnd_q;
    cout_d      = cout_q;
    omsb_d      = omsb_q;
    start       = 1'b0;
    mem_we      = 1'b0;
    mem_addr    = ea_q;
    mem_wdata   = opnd_q;
    if (wr_go) begin
      unique case (awaddr_q)
        `LRSC_OFS_CMD: begin
          // a command while busy is dropped; status shows busy
          if (st_q == LRSC_IDLE && legal) begin
            start = 1'b1;
          end else if (st_q == LRSC_IDLE) begin
            err_d = 1'b1;
          end
        end
        `LRSC_OFS_OPERAND: operand_d = 16'(wmerge({16'h0000, operand_q}, wdata_q, wstrb_q));
        `LRSC_OFS_COUNT:   count_low_d = wstrb_q[0] ? wdata_q[7:0] : count_low_q;
        `LRSC_OFS_IMM:     imm_d = wstrb_q[0] ? wdata_q[7:0] : imm_q;
        `LRSC_OFS_FLAGS:   flags_d = 16'(wmerge({16'h0000, flags_q}, wdata_q, wstrb_q)) & `LRSC_FLAGS_MASK;
        `LRSC_OFS_EA:      ea_d = wstrb_q[0] ? wdata_q[MEM_AW-1:0] : ea_q;
        `LRSC_OFS_MEMDATA: begin
          // the engine owns the port while it runs
          if (st_q == LRSC_IDLE) begin
            mem_we    = 1'b1;
            mem_wdata = wdata_q[15:0];
          end
        end
        default: ;
      endcase
    end
    if (start) begin
      st_d    = LRSC_RUN;
      cmd_d   = nc;
      err_d   = 1'b0;
      cyc_d   = lat_new;
      n_d     = n_new;
      steps_d = n_new;
      ea_x_d  = ea_q;
      opnd_d  = nc.mem ? mem_rdata : operand_q;
      omsb_d  = nc.opcode[0] ? opnd_d[15] : opnd_d[7];
    end
    if (st_q == LRSC_RUN) begin
      cyc_d = cyc_q - 6'h01;
      if (step) begin
        cout_d  = opnd_q[0];
        // zero enters at the top of the active width
        opnd_d  = cmd_q.opcode[0] ? {1'b0, opnd_q[15:1]} : {opnd_q[15:8], 1'b0, opnd_q[7:1]};
        steps_d = steps_q - 5'h01;
      end
      if (commit) begin
        st_d = LRSC_IDLE;
        // engine update wins over a software flag write in the same cycle
        flags_d = flags_q;
        if (cmd_q.opcode == `LRSC_OP_STC) begin
          flags_d[`LRSC_FLAG_CF] = 1'b1;
        end else begin
          if (n_q != 5'h00) begin
            flags_d[`LRSC_FLAG_CF] = cout_q;
            flags_d[`LRSC_FLAG_SF] = cmd_q.opcode[0] ? opnd_q[15] : opnd_q[7];
            flags_d[`LRSC_FLAG_ZF] = cmd_q.opcode[0] ? (opnd_q == 16'h0000) : (opnd_q[7:0] == 8'h00);
            flags_d[`LRSC_FLAG_PF] = ~^opnd_q[7:0];
            if (n_q == 5'h01) begin
              flags_d[`LRSC_FLAG_OF] = omsb_q;
            end
          end
          if (cmd_q.mem) begin
            mem_we    = 1'b1;
            mem_addr  = ea_x_q;
            mem_wdata = opnd_q;
          end else begin
            operand_d = opnd_q;
          end
        end
      end
    end
    busy_d = st_d == LRSC_RUN;
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_q        <= LRSC_IDLE;
      cmd_q       <= '0;
      operand_q   <= 16'h0000;
      flags_q     <= `LRSC_FLAGS_RST;
      count_low_q <= 8'h00;
      imm_q       <= 8'h00;
      ea_q        <= '0;
      ea_x_q      <= '0;
      err_q       <= 1'b0;
      busy_q      <= 1'b0;
      cyc_q       <= 6'h00;
      steps_q     <= 5'h00;
      n_q         <= 5'h00;
      opnd_q      <= 16'h0000;
      cout_q      <= 1'b0;
      omsb_q      <= 1'b0;
    end else if (CE_I) begin
      st_q        <= st_d;
      cmd_q       <= cmd_d;
      operand_q   <= operand_d;
      flags_q     <= flags_d;
      count_low_q <= count_low_d;
      imm_q       <= imm_d;
      ea_q        <= ea_d;
      ea_x_q      <= ea_x_d;
      err_q       <= err_d;
      busy_q      <= busy_d;
      cyc_q       <= cyc_d;
      steps_q     <= steps_d;
      n_q         <= n_d;
      opnd_q      <= opnd_d;
      cout_q      <= cout_d;
      omsb_q      <= omsb_d;
    end
  end

  lrsc_mem #(
    .AW (MEM_AW),
    .DW (16)
  ) u_mem (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .ce_i    (CE_I),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O  = wready_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign BUSY_O          = busy_q;
  assign CARRY_O         = flags_q[`LRSC_FLAG_CF];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [5:0] meas_q;
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      meas_q <= 6'h00;
    end else if (CE_I) begin
      meas_q <= start ? 6'h01 : (st_q == LRSC_RUN) ? 6'(meas_q + 6'h01) : meas_q;
    end
  end

  default clocking lrsc_cb @(posedge CLK_I iff CE_I); endclocking
  default disable iff (SYS_RST_I);

  property p_one_step; start && single |=> steps_q == 5'h01 && n_q == 5'h01; endproperty
  a_one_step: assert property (p_one_step) else $error("single shift not one step");
  property p_cl_src; start && by_cl |=> steps_q == $past(cl_cnt); endproperty
  a_cl_src: assert property (p_cl_src) else $error("count not from count register");
  property p_imm_src; start && by_imm |=> steps_q == $past(imm_cnt); endproperty
  a_imm_src: assert property (p_imm_src) else $error("count not from immediate");
  property p_lat_one;
    commit && (cmd_q.opcode inside {`LRSC_OP_ONE_B, `LRSC_OP_ONE_W}) |-> meas_q == (cmd_q.mem ? 6'h0F : 6'h02);
  endproperty
  a_lat_one: assert property (p_lat_one) else $error("single shift latency wrong");
  property p_lat_mul;
    commit && (cmd_q.opcode inside {`LRSC_OP_CL_B, `LRSC_OP_CL_W, `LRSC_OP_IMM_B, `LRSC_OP_IMM_W})
      |-> meas_q == (cmd_q.mem ? 6'h11 : 6'h05) + {1'b0, n_q};
  endproperty
  a_lat_mul: assert property (p_lat_mul) else $error("multi shift latency wrong");
  property p_zero_fill; step && cmd_q.opcode[0] |=> opnd_q == ($past(opnd_q) >> 1); endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("word step not zero filled");
  property p_carry_out; step |=> cout_q == $past(opnd_q[0]); endproperty
  a_carry_out: assert property (p_carry_out) else $error("low bit not caught");
  property p_cnt_mask; start && (by_cl || by_imm) |=> st_q == LRSC_RUN && steps_q == n_q && cyc_q <= 6'h30; endproperty
  a_cnt_mask: assert property (p_cnt_mask) else $error("count exceeds five bits");
  property p_zero_keep; commit && cmd_q.opcode != `LRSC_OP_STC && n_q == 5'h00 |=> flags_q == $past(flags_q); endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero count touched flags");
  property p_of_one; commit && n_q == 5'h01 |=> flags_q[`LRSC_FLAG_OF] == $past(omsb_q); endproperty
  a_of_one: assert property (p_of_one) else $error("overflow not original msb");
  property p_lat_stc; commit && cmd_q.opcode == `LRSC_OP_STC |-> meas_q == 6'h02; endproperty
  a_lat_stc: assert property (p_lat_stc) else $error("set carry latency wrong");
  property p_stc_set; commit && cmd_q.opcode == `LRSC_OP_STC |=> flags_q == ($past(flags_q) | 16'h0001); endproperty
  a_stc_set: assert property (p_stc_set) else $error("set carry changed other flags");
  property p_mem_wb; commit && cmd_q.mem |-> mem_we && mem_addr == ea_x_q && mem_wdata == opnd_q; endproperty
  a_mem_wb: assert property (p_mem_wb) else $error("memory writeback missing");

  c_stc: cover property (start && is_stc ##2 commit);
  c_mem_mul: cover property (commit && cmd_q.mem && n_q > 5'h01);
  c_zero_cnt: cover property (commit && by_cl == 1'b0 && n_q == 5'h00 && cmd_q.opcode != `LRSC_OP_STC);
endmodule

// ==== verif/lrsc_axi_host.sv ====
`timescale 1ns/10ps
module lrsc_axi_host (
  // clock
  input  wire logic        clk_i,
  // write side
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  // read side
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // released lines carry the inverse so a stale value never looks current
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o  <= a;
    awvalid_o <= 1'b1;
    wdata_o   <= d;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~d;
      end
      if (bvalid_i) begin
        r = bresp_i;
        bready_o <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o  <= a;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~a;
      end
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        break;
      end
    end
  endtask
endmodule

// ==== verif/lrsc_tb_top.sv ====
`timescale 1ns/10ps
`include "lrsc_cfg.svh"
module lrsc_tb_top;
  import lrsc_pkg::*;
  typedef struct {
    logic [11:0] cmd;
    logic [15:0] opnd;
    logic [7:0]  cnt, imm;
    logic [15:0] fin, res, fl, msk;
    int          lat;
  } lrsc_row_t;
  // cmd, operand, count, imm, flags in, result, flags out, flag mask, cycles
  lrsc_row_t rows [9] = '{
    '{12'h5D1, 16'h8003, 8'h04, 8'h02, 16'h0000, 16'h4001, 16'h0801, 16'h0801, 2},
    '{12'h5D0, 16'h1281, 8'h04, 8'h02, 16'h0000, 16'h1240, 16'h0801, 16'h0801, 2},
    '{12'h5D3, 16'hF00F, 8'h04, 8'h02, 16'h0800, 16'h0F00, 16'h0801, 16'h0801, 9},
    '{12'h5D2, 16'h00F4, 8'h03, 8'h02, 16'h0000, 16'h001E, 16'h0001, 16'h0801, 8},
    '{12'h5C1, 16'h0002, 8'h04, 8'h21, 16'h0801, 16'h0001, 16'h0000, 16'h0801, 6},
    '{12'h5C0, 16'h00AB, 8'h04, 8'h20, 16'h0801, 16'h00AB, 16'h0801, 16'hFFFF, 5},
    '{12'h5D3, 16'h8000, 8'h3F, 8'h02, 16'h0001, 16'h0000, 16'h0000, 16'h0801, 36},
    '{12'h0F9, 16'h1234, 8'h04, 8'h02, 16'h0FD4, 16'h1234, 16'h0FD5, 16'hFFFF, 2},
    '{12'h0F9, 16'h0055, 8'h04, 8'h02, 16'h0001, 16'h0055, 16'h0001, 16'hFFFF, 2}
  };
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [31:0] busy_cnt = '0;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, busy, carry;
  int          fails = 0, check_count = 0, cyc = 0;

  lrsc_top u_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .BUSY_O(busy), .CARRY_O(carry));
  lrsc_axi_host u_host (
    .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
    .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready));

  always #20 clk = ~clk;

  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    u_host.rd(a, d, r);
    chk(d & m, e & m);
  endtask
  // busy is read at the falling edge, well clear of the edge that moves it
  task automatic run(input logic [31:0] cmd, input int lat, input int hold = 0);
    int k;
    k = 0;
    busy_cnt <= '0;
    u_host.wr(`LRSC_OFS_CMD, cmd, r);
    // a low enable freezes the engine, so each held cycle stretches busy by one
    if (hold > 0) begin
      ce <= 1'b0;
      repeat (hold) @(posedge clk);
      ce <= 1'b1;
    end
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 200);
    chk(busy_cnt, 32'(lat + hold));
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1)
      busy_cnt <= busy_cnt + 32'h1;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(`LRSC_OFS_FLAGS, 32'h0, 32'hFFFF);
    chk({31'h0, carry}, 32'h0);
    foreach (rows[i]) begin
      u_host.wr(`LRSC_OFS_OPERAND, {16'h0, rows[i].opnd}, r);
      u_host.wr(`LRSC_OFS_COUNT, {24'h0, rows[i].cnt}, r);
      u_host.wr(`LRSC_OFS_IMM, {24'h0, rows[i].imm}, r);
      u_host.wr(`LRSC_OFS_FLAGS, {16'h0, rows[i].fin}, r);
      run({20'h0, rows[i].cmd}, rows[i].lat);
      rdc(`LRSC_OFS_OPERAND, {16'h0, rows[i].res}, 32'hFFFF);
      rdc(`LRSC_OFS_FLAGS, {16'h0, rows[i].fl}, {16'h0, rows[i].msk});
      chk({31'h0, carry}, {31'h0, rows[i].fl[0]});
    end
    u_host.wr(`LRSC_OFS_EA, 32'h3, r);
    u_host.wr(`LRSC_OFS_MEMDATA, 32'h6, r);
    u_host.wr(`LRSC_OFS_COUNT, 32'h2, r);
    run(32'hDD1, 15);
    rdc(`LRSC_OFS_MEMDATA, 32'h3, 32'hFFFF);
    rdc(`LRSC_OFS_FLAGS, 32'h0, 32'h0801);
    run(32'hDD3, 19);
    rdc(`LRSC_OFS_MEMDATA, 32'h0, 32'hFFFF);
    rdc(`LRSC_OFS_FLAGS, 32'h1, 32'h0801);
    u_host.rd(8'h20, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `LRSC_RESP_SLVERR});
    u_host.wr(8'h24, 32'h1, r);
    chk({30'h0, r}, {30'h0, `LRSC_RESP_SLVERR});
    // wrong reg field: no run, error flag up
    u_host.wr(`LRSC_OFS_CMD, 32'h4D1, r);
    rdc(`LRSC_OFS_STATUS, 32'h2, 32'h3);
    u_host.wr(`LRSC_OFS_OPERAND, 32'h10, r);
    run(32'h5D1, 2, 3);
    rdc(`LRSC_OFS_OPERAND, 32'h8, 32'hFFFF);
    rdc(`LRSC_OFS_STATUS, 32'h0, 32'h3);
    // reset in mid-run drops the command and clears the registers
    u_host.wr(`LRSC_OFS_CMD, 32'h5D3, r);
    rst <= 1'b1;
    @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    rdc(`LRSC_OFS_OPERAND, 32'h0, 32'hFFFF);
    rdc(`LRSC_OFS_FLAGS, 32'h0, 32'hFFFF);
    chk({31'h0, carry}, 32'h0);
    wrap_up();
  end
endmodule
